//--- ccs_pkg.sv
// Purpose: Shared constants, state encoding and decode helpers of the CPU clock source control.
// Assumes: A 32-bit APB register window where each register takes one aligned word.
// Notes:   Oscillator activity is seen as one-cycle tick pulses on pclk.
package ccs_pkg;

  // Register byte offsets.
  localparam logic [7:0] MAIN_CLOCK_MODE_OFS    = 8'h00;
  localparam logic [7:0] FAST_OSC_CONTROL_OFS   = 8'h04;
  localparam logic [7:0] SLOW_OSC_MODE_OFS      = 8'h08;
  localparam logic [7:0] CPU_CLOCK_DIVIDER_OFS  = 8'h0c;
  localparam logic [7:0] OSC_SETTLE_SELECT_OFS  = 8'h10;
  localparam logic [7:0] OSC_SETTLE_STATUS_OFS  = 8'h14;

  // Field positions.
  localparam int unsigned SEL_BIT       = 0;
  localparam int unsigned STATUS_BIT    = 1;
  localparam int unsigned FAST_STOP_BIT = 7;
  localparam int unsigned SLOW_STOP_BIT = 0;
  localparam int unsigned DIV_W         = 3;
  localparam int unsigned SETTLE_SEL_W  = 3;
  localparam int unsigned SETTLE_CNT_W  = 16;

  // Reset values.
  localparam logic             SEL_RST        = 1'b0;
  localparam logic             FAST_STOP_RST  = 1'b0;
  localparam logic             SLOW_STOP_RST  = 1'b0;
  localparam logic [DIV_W-1:0] DIV_RST        = 3'h0;
  localparam logic [2:0]       SETTLE_SEL_RST = 3'h4;

  // Timing counts.
  localparam logic [4:0] HOLD_SLOW_CYCLES  = 5'h11;
  localparam logic [1:0] SW_UP_CPU_CLOCKS  = 2'h2;
  localparam logic [2:0] DIV_MAX_SETTING   = 3'h4;
  // Software-side figures, kept for reference by firmware and benches.
  localparam int unsigned FAST_SETTLE_WAIT_US = 350;
  localparam int unsigned SLOW_OSC_WORST_KHZ  = 120;

  // Run state codes reported on run_state.
  localparam logic [1:0] RUN_FAST_BOTH_ON  = 2'h0;
  localparam logic [1:0] RUN_SLOW_BOTH_ON  = 2'h1;
  localparam logic [1:0] RUN_SLOW_FAST_OFF = 2'h2;
  localparam logic [1:0] RUN_FAST_SLOW_OFF = 2'h3;

  // Controller modes, Gray coded along reset, start, run, standby.
  typedef enum logic [2:0] {
    CCS_HOLD   = 3'h0,
    CCS_START  = 3'h1,
    CCS_RUN    = 3'h3,
    CCS_HALT   = 3'h2,
    CCS_STOP   = 3'h6,
    CCS_SETTLE = 3'h7
  } ccs_mode_t;

  // Settle threshold in fast oscillator cycles for one select value.
  function automatic logic [SETTLE_CNT_W-1:0] ccs_settle_thr(input logic [2:0] sel);
    case (sel)
      3'h0:    ccs_settle_thr = 16'h0800;
      3'h1:    ccs_settle_thr = 16'h2000;
      3'h2:    ccs_settle_thr = 16'h4000;
      default: ccs_settle_thr = 16'h8000;
    endcase
  endfunction : ccs_settle_thr

  // True once the settle counter reached the threshold of a select value.
  function automatic logic ccs_settle_done(input logic [SETTLE_CNT_W-1:0] cnt,
                                           input logic [2:0]              sel);
    ccs_settle_done = (cnt >= ccs_settle_thr(sel));
  endfunction : ccs_settle_done

  // Old CPU clocks a divider rewrite waits, from the setting before the switch.
  function automatic logic [4:0] ccs_div_latency(input logic [DIV_W-1:0] old_div);
    case (old_div)
      3'h0:    ccs_div_latency = 5'h10;
      3'h1:    ccs_div_latency = 5'h08;
      3'h2:    ccs_div_latency = 5'h04;
      3'h3:    ccs_div_latency = 5'h02;
      default: ccs_div_latency = 5'h01;
    endcase
  endfunction : ccs_div_latency

endpackage : ccs_pkg

//--- ccs_cpu_divider.sv
// Purpose: Divides the selected source tick into CPU clock ticks by a power of two.
// Assumes: src_tick is a one-cycle pulse per source clock cycle, synchronous to pclk.
// Notes:   Settings above the largest one divide as the largest one.
`timescale 1ns/10ps
module ccs_cpu_divider #(
  parameter int unsigned DIV_W   = 3,
  parameter int unsigned MAX_DIV = 4
) (
  // Clock and reset.
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Source tick and division setting.
  input  wire logic             src_tick,
  input  wire logic [DIV_W-1:0] div,
  // Divided tick.
  output logic                  cpu_tick
);

  typedef struct packed {
    logic [MAX_DIV-1:0] cnt;
  } ccs_div_state_t;

  ccs_div_state_t     st;
  ccs_div_state_t     next_st;
  logic [MAX_DIV-1:0] mask;

  // The counter width is fixed by the largest division exponent.
  initial
  begin
    if (MAX_DIV < 1 || MAX_DIV >= (1 << DIV_W))
      $error("ccs_cpu_divider: MAX_DIV out of range");
  end

  // Mask of low counter bits that must all be set for a tick to pass.
  always_comb
  begin
    mask = '0;
    for (int i = 0; i < MAX_DIV; i++)
      if (i < int'(div))
        mask[i] = 1'b1;
  end

  assign cpu_tick = src_tick && ((st.cnt & mask) == mask);

  // Free count of source ticks; the low bits select the phase.
  always_comb
  begin
    next_st = st;
    if (src_tick)
      next_st.cnt = st.cnt + 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st <= '0;
    else
      st <= next_st;
  end

endmodule : ccs_cpu_divider

//--- ccs_clock_ctrl.sv
// Purpose: CPU clock source, divider, oscillator gating and standby control.
// Assumes: Oscillator ticks and standby requests are synchronous one-cycle pulses.
// Notes:   Registers sit on APB with zero wait states.
// Function
// - Stoppable slow option: watchdog halts in standby, slow oscillator runs unless stopped.
// - Non-stoppable option: watchdog keeps counting in STOP; overflow resets.
// - Reset pin, power-on clear, low voltage and watchdog overflow all force reset.
// - Reset stops both oscillators and prescaler; CPU restarts on slow clock.
// - STOP halts fast oscillator and prescaler; CPU resumes on its earlier clock.
// - HALT keeps oscillators per flags; peripherals fed by the selected clock.
// - Slow oscillator stop flag only counts with the stoppable option.
// - Fast stop flag is bit 7, slow stop flag is bit 0; 1 stops.
// - Select bit 0: 0 picks slow clock, 1 picks fast clock for the CPU.
// - Status bit 1 shows the real CPU source, updated when switching ends.
// - Three-bit divider field; a rewrite applies after a delay on the old clock.
// - Divider delay is 16, 8, 4, 2 or 1 old clocks by old setting.
// - Settle wait applies only to STOP release while on the fast clock.
// - After reset the CPU clock is held for 17 slow clock cycles.
// - Fast oscillator runs regardless of its flag while it clocks the CPU.
// - Slow oscillator runs regardless of its flag while it clocks the CPU.
`timescale 1ns/10ps
module ccs_clock_ctrl #(
  parameter int unsigned ADDR_W = 8
) (
  // Clock and reset.
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave.
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Reset sources.
  input  wire logic              reset_pin_n,
  input  wire logic              power_on_clear,
  input  wire logic              low_voltage_detect,
  input  wire logic              watchdog_overflow,
  // Option strap and oscillator ticks.
  input  wire logic              slow_osc_stoppable,
  input  wire logic              fast_tick,
  input  wire logic              slow_tick,
  // Standby requests and wake-up.
  input  wire logic              halt_req,
  input  wire logic              stop_req,
  input  wire logic              wake_irq,
  // Clock control outputs.
  output logic                   fast_osc_en,
  output logic                   slow_osc_en,
  output logic                   cpu_clk_en,
  output logic                   periph_clk_en,
  output logic                   periph_clk_sel,
  output logic                   watchdog_run,
  output logic [1:0]             run_state,
  output logic                   cpu_clock_source_status
);

  typedef struct packed {
    ccs_pkg::ccs_mode_t                  mode;
    logic                                sel;
    logic                                status;
    logic                                fast_stop;
    logic                                slow_stop;
    logic [ccs_pkg::DIV_W-1:0]           div;
    logic                                div_pend;
    logic [ccs_pkg::DIV_W-1:0]           div_new;
    logic [4:0]                          div_cnt;
    logic                                sw_busy;
    logic                                sw_seen;
    logic [1:0]                          sw_cnt;
    logic [2:0]                          settle_sel;
    logic [ccs_pkg::SETTLE_CNT_W-1:0]    settle_cnt;
    logic [4:0]                          hold_cnt;
    logic                                stoppable;
  } ccs_state_t;

  localparam ccs_state_t ST_RST = '{
    mode:       ccs_pkg::CCS_HOLD,
    sel:        ccs_pkg::SEL_RST,
    status:     ccs_pkg::SEL_RST,
    fast_stop:  ccs_pkg::FAST_STOP_RST,
    slow_stop:  ccs_pkg::SLOW_STOP_RST,
    div:        ccs_pkg::DIV_RST,
    div_pend:   1'b0,
    div_new:    ccs_pkg::DIV_RST,
    div_cnt:    5'h00,
    sw_busy:    1'b0,
    sw_seen:    1'b0,
    sw_cnt:     2'h0,
    settle_sel: ccs_pkg::SETTLE_SEL_RST,
    settle_cnt: 16'h0000,
    hold_cnt:   5'h00,
    stoppable:  1'b0
  };

  ccs_state_t st;
  ccs_state_t next_st;
  logic       any_rst;
  logic       held;
  logic       standby;
  logic       src_tick;
  logic       cpu_tick;
  logic       wr;
  logic       rd_hit;
  logic [7:0] ofs;
  logic       upper_zero;

  initial
  begin
    if (ADDR_W < 8)
      $error("ccs_clock_ctrl: ADDR_W must be at least 8");
  end

  // Every reset source is treated alike and holds the controller in reset.
  assign any_rst = !reset_pin_n || power_on_clear || low_voltage_detect
                   || watchdog_overflow;
  assign held    = (st.mode == ccs_pkg::CCS_HOLD);
  assign standby = (st.mode == ccs_pkg::CCS_HALT) || (st.mode == ccs_pkg::CCS_STOP)
                   || (st.mode == ccs_pkg::CCS_SETTLE);

  // Oscillator enables; the clock that feeds the CPU cannot be stopped by its flag.
  assign fast_osc_en = !held && (st.mode != ccs_pkg::CCS_STOP)
                       && (st.status || st.sel || !st.fast_stop);
  assign slow_osc_en = !held
                       && (!st.status || !st.stoppable || !st.slow_stop);

  // Prescaler runs in RUN and HALT only, on the clock the select bit names.
  assign periph_clk_en  = (st.mode == ccs_pkg::CCS_RUN)
                          || (st.mode == ccs_pkg::CCS_HALT);
  assign periph_clk_sel = st.sel;

  // With the stoppable option the watchdog rests during any standby.
  assign watchdog_run = !held && !(st.stoppable && standby);

  // The CPU is clocked only in RUN, from the source the status bit reports.
  assign src_tick   = (st.mode == ccs_pkg::CCS_RUN)
                      && (st.status ? fast_tick : slow_tick);
  assign cpu_clk_en = cpu_tick;
  assign cpu_clock_source_status = st.status;

  // Run state from the real source and which oscillator is off.
  always_comb
  begin
    if (st.status)
      run_state = slow_osc_en ? ccs_pkg::RUN_FAST_BOTH_ON
                              : ccs_pkg::RUN_FAST_SLOW_OFF;
    else
      run_state = fast_osc_en ? ccs_pkg::RUN_SLOW_BOTH_ON
                              : ccs_pkg::RUN_SLOW_FAST_OFF;
  end

  ccs_cpu_divider #(
    .DIV_W   (ccs_pkg::DIV_W),
    .MAX_DIV (4)
  ) u_div (
    .pclk     (pclk),
    .presetn  (presetn),
    .src_tick (src_tick),
    .div      (st.div),
    .cpu_tick (cpu_tick)
  );

  // APB decode; no wait states, unmapped words answer with an error.
  assign ofs        = paddr[7:0];
  assign upper_zero = (paddr >> 8) == '0;
  assign wr         = psel && penable && pwrite && upper_zero;
  assign pready     = 1'b1;
  assign rd_hit     = upper_zero && ((ofs == ccs_pkg::MAIN_CLOCK_MODE_OFS)
                      || (ofs == ccs_pkg::FAST_OSC_CONTROL_OFS)
                      || (ofs == ccs_pkg::SLOW_OSC_MODE_OFS)
                      || (ofs == ccs_pkg::CPU_CLOCK_DIVIDER_OFS)
                      || (ofs == ccs_pkg::OSC_SETTLE_SELECT_OFS)
                      || (ofs == ccs_pkg::OSC_SETTLE_STATUS_OFS));
  assign pslverr    = psel && penable && !rd_hit;

  // Read mux; bits not listed read as zero.
  always_comb
  begin
    prdata = 32'h0000_0000;
    case (ofs)
      ccs_pkg::MAIN_CLOCK_MODE_OFS:
      begin
        prdata[ccs_pkg::SEL_BIT]    = st.sel;
        prdata[ccs_pkg::STATUS_BIT] = st.status;
      end
      ccs_pkg::FAST_OSC_CONTROL_OFS: prdata[ccs_pkg::FAST_STOP_BIT] = st.fast_stop;
      ccs_pkg::SLOW_OSC_MODE_OFS:    prdata[ccs_pkg::SLOW_STOP_BIT] = st.slow_stop;
      ccs_pkg::CPU_CLOCK_DIVIDER_OFS:
        prdata[ccs_pkg::DIV_W-1:0] = st.div_pend ? st.div_new : st.div;
      ccs_pkg::OSC_SETTLE_SELECT_OFS: prdata[2:0] = st.settle_sel;
      ccs_pkg::OSC_SETTLE_STATUS_OFS:
        for (int i = 0; i < 5; i++)
          prdata[i] = ccs_pkg::ccs_settle_done(st.settle_cnt, 3'(i));
      default: prdata = 32'h0000_0000;
    endcase
    if (!upper_zero)
      prdata = 32'h0000_0000;
  end

  // Next state: mode sequencing, register writes, delayed switches.
  always_comb
  begin
    next_st = st;
    case (st.mode)
      ccs_pkg::CCS_HOLD:
      begin
        // A power-up reset alone must also pick up the option strap.
        next_st.hold_cnt  = 5'h00;
        next_st.stoppable = slow_osc_stoppable;
        if (!any_rst)
          next_st.mode = ccs_pkg::CCS_START;
      end
      ccs_pkg::CCS_START:
      begin
        // The CPU clock is withheld until the slow oscillator has run a while.
        if (slow_tick)
          next_st.hold_cnt = st.hold_cnt + 5'h01;
        if (slow_tick && (st.hold_cnt + 5'h01 == ccs_pkg::HOLD_SLOW_CYCLES))
          next_st.mode = ccs_pkg::CCS_RUN;
      end
      ccs_pkg::CCS_RUN:
      begin
        if (stop_req)
          next_st.mode = ccs_pkg::CCS_STOP;
        else if (halt_req)
          next_st.mode = ccs_pkg::CCS_HALT;
      end
      ccs_pkg::CCS_HALT:
        if (wake_irq)
          next_st.mode = ccs_pkg::CCS_RUN;
      ccs_pkg::CCS_STOP:
        if (wake_irq)
          next_st.mode = st.status ? ccs_pkg::CCS_SETTLE
                                   : ccs_pkg::CCS_RUN;
      ccs_pkg::CCS_SETTLE:
        if (ccs_pkg::ccs_settle_done(st.settle_cnt, st.settle_sel))
          next_st.mode = ccs_pkg::CCS_RUN;
      default: next_st.mode = ccs_pkg::CCS_HOLD;
    endcase

    // Settle counter restarts whenever the fast oscillator is off.
    if (!fast_osc_en)
      next_st.settle_cnt = '0;
    else if (fast_tick && (st.settle_cnt != '1))
      next_st.settle_cnt = st.settle_cnt + 1'b1;

    // Source switch: fast to slow waits a slow edge then one CPU clock.
    if (st.sw_busy)
    begin
      if (st.status)
      begin
        if (slow_tick)
          next_st.sw_seen = 1'b1;
        if ((st.sw_seen || slow_tick) && cpu_tick)
        begin
          next_st.status  = 1'b0;
          next_st.sw_busy = 1'b0;
        end
      end
      else if (cpu_tick)
      begin
        next_st.sw_cnt = st.sw_cnt + 2'h1;
        if (st.sw_cnt + 2'h1 == ccs_pkg::SW_UP_CPU_CLOCKS)
        begin
          next_st.status  = 1'b1;
          next_st.sw_busy = 1'b0;
        end
      end
    end

    // Divider rewrite: the old setting keeps running for its latency.
    if (st.div_pend && cpu_tick)
    begin
      next_st.div_cnt = st.div_cnt + 5'h01;
      if (st.div_cnt + 5'h01 >= ccs_pkg::ccs_div_latency(st.div))
      begin
        next_st.div      = st.div_new;
        next_st.div_pend = 1'b0;
      end
    end

    // Register writes; a write wins over the switch logic above.
    if (wr && !held)
    begin
      case (ofs)
        ccs_pkg::MAIN_CLOCK_MODE_OFS:
        begin
          next_st.sel     = pwdata[ccs_pkg::SEL_BIT];
          next_st.sw_busy = (pwdata[ccs_pkg::SEL_BIT] != next_st.status);
          next_st.sw_seen = 1'b0;
          next_st.sw_cnt  = 2'h0;
        end
        ccs_pkg::FAST_OSC_CONTROL_OFS:
          next_st.fast_stop = pwdata[ccs_pkg::FAST_STOP_BIT];
        ccs_pkg::SLOW_OSC_MODE_OFS:
          next_st.slow_stop = pwdata[ccs_pkg::SLOW_STOP_BIT];
        ccs_pkg::CPU_CLOCK_DIVIDER_OFS:
        begin
          next_st.div_new  = pwdata[ccs_pkg::DIV_W-1:0];
          next_st.div_pend = (pwdata[ccs_pkg::DIV_W-1:0] != next_st.div);
          next_st.div_cnt  = 5'h00;
        end
        ccs_pkg::OSC_SETTLE_SELECT_OFS: next_st.settle_sel = pwdata[2:0];
        default: next_st.settle_sel = next_st.settle_sel;
      endcase
    end

    // Any reset source returns everything to the reset state; the strap is
    // sampled here by a clocked path, never by the asynchronous reset.
    if (any_rst)
    begin
      next_st           = ST_RST;
      next_st.stoppable = slow_osc_stoppable;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st <= ST_RST;
    else
      st <= next_st;
  end

endmodule : ccs_clock_ctrl

//--- ccs_clock_ctrl_props.sv
// Purpose: Concurrent checks on the ports of the CPU clock source control.
// Assumes: Reset sources are synchronous levels; requests are one-cycle pulses.
// Notes:   The option strap is captured here the same way the block captures it.
`timescale 1ns/10ps
module ccs_clock_ctrl_props (
  // Clock and reset.
  input wire logic       pclk,
  input wire logic       presetn,
  // Reset sources and option strap.
  input wire logic       reset_pin_n,
  input wire logic       power_on_clear,
  input wire logic       low_voltage_detect,
  input wire logic       watchdog_overflow,
  input wire logic       slow_osc_stoppable,
  // Standby requests.
  input wire logic       halt_req,
  input wire logic       stop_req,
  // Watched outputs.
  input wire logic       fast_osc_en,
  input wire logic       slow_osc_en,
  input wire logic       cpu_clk_en,
  input wire logic       periph_clk_en,
  input wire logic       watchdog_run,
  input wire logic [1:0] run_state,
  input wire logic       cpu_clock_source_status
);
  logic any_src;
  logic strap_q;
  logic held_q;

  // Any of the four reset sources forces the hold state.
  assign any_src = !reset_pin_n || power_on_clear || low_voltage_detect || watchdog_overflow;

  // The strap counts as captured while the block is held, so a later change is ignored.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      held_q  <= 1'b1;
      strap_q <= 1'b0;
    end
    else
    begin
      held_q <= any_src;
      if (any_src || held_q)
        strap_q <= slow_osc_stoppable;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  hold_gate_a: assert property (
    any_src |=> !fast_osc_en && !slow_osc_en && !cpu_clk_en && !periph_clk_en
                && !cpu_clock_source_status)
    else $error("Clock outputs active one cycle after a reset source");
  fast_keep_a: assert property (
    cpu_clock_source_status && cpu_clk_en |-> fast_osc_en)
    else $error("Fast oscillator off while it clocks the CPU");
  slow_keep_a: assert property (
    !cpu_clock_source_status && cpu_clk_en |-> slow_osc_en)
    else $error("Slow oscillator off while it clocks the CPU");
  status_move_a: assert property (
    $changed(cpu_clock_source_status) |-> $past(cpu_clk_en) || $past(any_src))
    else $error("Source status changed without a CPU tick");
  run_code_a: assert property (
    cpu_clk_en |-> (^run_state) == !cpu_clock_source_status)
    else $error("Run state code disagrees with the CPU source");
  stop_gate_a: assert property (
    stop_req && periph_clk_en && !any_src |=> !periph_clk_en && !fast_osc_en && !cpu_clk_en)
    else $error("Clocks still running after entering STOP");
  halt_keep_a: assert property (
    halt_req && !stop_req && periph_clk_en && !any_src |=> (periph_clk_en && !cpu_clk_en)[*2])
    else $error("HALT did not keep peripherals and stop the CPU");
  wd_stop_a: assert property (
    stop_req && periph_clk_en && !any_src |=> watchdog_run == !strap_q
                                              && (strap_q || slow_osc_en))
    else $error("Watchdog or slow oscillator wrong in STOP");
  wd_halt_a: assert property (
    halt_req && !stop_req && periph_clk_en && strap_q && !any_src |=> !watchdog_run)
    else $error("Watchdog runs in HALT with the stoppable option");

  // Main scenarios reached.
  stop_seen_c: cover property (stop_req && periph_clk_en);
  halt_seen_c: cover property (halt_req && periph_clk_en);
  up_seen_c:   cover property ($rose(cpu_clock_source_status));
  down_seen_c: cover property ($fell(cpu_clock_source_status) && !any_src);
endmodule : ccs_clock_ctrl_props

bind ccs_clock_ctrl ccs_clock_ctrl_props u_props (
  .pclk(pclk), .presetn(presetn), .reset_pin_n(reset_pin_n),
  .power_on_clear(power_on_clear), .low_voltage_detect(low_voltage_detect),
  .watchdog_overflow(watchdog_overflow), .slow_osc_stoppable(slow_osc_stoppable),
  .halt_req(halt_req), .stop_req(stop_req), .fast_osc_en(fast_osc_en),
  .slow_osc_en(slow_osc_en), .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
  .watchdog_run(watchdog_run), .run_state(run_state),
  .cpu_clock_source_status(cpu_clock_source_status));

//--- ccs_clock_ctrl_test.sv
// Purpose: Self-checking bench of the CPU clock source control over APB.
// Assumes: Fast oscillator ticks every pclk cycle, slow one every eighth, while enabled.
// Notes:   Settle select 0 keeps the STOP wake on the fast clock short.
`timescale 1ns/10ps
module ccs_clock_ctrl_test;
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [3:0]  src     = 4'h0;
  logic [2:0]  req     = 3'h0;
  logic [2:0]  scnt    = 3'h0;
  logic        strap   = 1'b0;
  logic        fast_tick = 1'b0;
  logic        slow_tick = 1'b0;
  logic [31:0] prdata, rdat;
  logic        pready, pslverr, perr, fast_osc_en, slow_osc_en, cpu_clk_en;
  logic        periph_clk_en, periph_clk_sel, watchdog_run, stat;
  logic [1:0]  run_state;
  int          fail_count = 0;
  int          cmp_count  = 0;
  int          cyc        = 0;
  int          n, m;

  `define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin fail_count++; \
    $display("MISMATCH %s expected %0h seen %0h", nm, (e), (g)); end end

  ccs_clock_ctrl dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .reset_pin_n(~src[0]), .power_on_clear(src[1]), .low_voltage_detect(src[2]),
    .watchdog_overflow(src[3]), .slow_osc_stoppable(strap), .fast_tick(fast_tick),
    .slow_tick(slow_tick), .halt_req(req[0]), .stop_req(req[1]), .wake_irq(req[2]),
    .fast_osc_en(fast_osc_en), .slow_osc_en(slow_osc_en), .cpu_clk_en(cpu_clk_en),
    .periph_clk_en(periph_clk_en), .periph_clk_sel(periph_clk_sel),
    .watchdog_run(watchdog_run), .run_state(run_state), .cpu_clock_source_status(stat));

  always #5 pclk = ~pclk;

  // Oscillators give no ticks while disabled, as real ones would.
  always @(posedge pclk)
  begin
    scnt <= scnt + 3'h1;
    slow_tick <= slow_osc_en && (scnt == 3'h7);
    fast_tick <= fast_osc_en;
  end

  // A hung wait ends the run as a failure.
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      fail_count++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("Compares %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : give_verdict

  // One APB transfer; the request stands until pready is seen high at an edge.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    perr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK("prdata", e, rdat)
  endtask : rchk

  // A one-cycle pulse on a standby request: 0 halt, 1 stop, 2 wake.
  task automatic pulse(input int b);
    @(posedge pclk);
    req[b] <= 1'b1;
    @(posedge pclk);
    req[b] <= 1'b0;
  endtask : pulse

  // Counts CPU ticks over a number of cycles, starting with the current cycle.
  task automatic count(input int c, output int k);
    k = 0;
    repeat (c)
    begin
      #1;
      k += int'(cpu_clk_en === 1'b1);
      @(posedge pclk);
    end
  endtask : count

  // Counts CPU ticks until the source status shows the wanted value.
  task automatic wstat(input logic v, output int k);
    k = 0;
    repeat (300)
    begin
      #1;
      if (stat === v)
        break;
      k += int'(cpu_clk_en === 1'b1);
      @(posedge pclk);
    end
  endtask : wstat

  // Cycles and slow ticks that pass before the first CPU tick.
  task automatic first_tick(output int k, output int s);
    k = 0;
    s = 0;
    repeat (2500)
    begin
      #1;
      if (cpu_clk_en === 1'b1)
        break;
      k++;
      s += int'(slow_tick === 1'b1);
      @(posedge pclk);
    end
  endtask : first_tick

  // Main sequence; the strap is 0 until the reset sources are exercised.
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    first_tick(n, m);
    `CHK("start_ticks", 17, m)
    for (int i = 0; i < 5; i++)
      rchk(8'(i * 4), (i == 4) ? 32'(ccs_pkg::SETTLE_SEL_RST) : 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    `CHK("pslverr", 1'b1, perr)
    `CHK("run_state", 2'h1, run_state)
    wr(ccs_pkg::SLOW_OSC_MODE_OFS, 32'h1);
    #1;
    `CHK("slow_osc_en", 1'b1, slow_osc_en)
    wr(ccs_pkg::SLOW_OSC_MODE_OFS, 32'h0);
    wr(ccs_pkg::FAST_OSC_CONTROL_OFS, 32'h80);
    #1;
    `CHK("fast_osc_en", 1'b0, fast_osc_en)
    `CHK("run_state", 2'h2, run_state)
    wr(ccs_pkg::FAST_OSC_CONTROL_OFS, 32'h0);
    pulse(1);
    #1;
    `CHK("watchdog_run", 1'b1, watchdog_run)
    pulse(2);
    count(40, n);
    `CHK("wake_slow", 1'b1, n > 2 && stat === 1'b0)
    repeat (2100) @(posedge pclk);
    rchk(ccs_pkg::OSC_SETTLE_STATUS_OFS, 32'h1);
    wr(ccs_pkg::MAIN_CLOCK_MODE_OFS, 32'h1);
    wstat(1'b1, n);
    `CHK("switch_up", 2, n)
    `CHK("run_state", 2'h0, run_state)
    `CHK("periph_clk_sel", 1'b1, periph_clk_sel)
    rchk(ccs_pkg::MAIN_CLOCK_MODE_OFS, 32'h3);
    wr(ccs_pkg::CPU_CLOCK_DIVIDER_OFS, 32'h2);
    count(40, n);
    `CHK("div_ticks", 1'b1, n >= 20 && n <= 23)
    rchk(ccs_pkg::CPU_CLOCK_DIVIDER_OFS, 32'h2);
    wr(ccs_pkg::CPU_CLOCK_DIVIDER_OFS, 32'h0);
    repeat (20) @(posedge pclk);
    pulse(0);
    count(20, n);
    `CHK("halt_ticks", 0, n)
    `CHK("periph_clk_en", 1'b1, periph_clk_en)
    pulse(2);
    count(20, n);
    `CHK("wake_halt", 1'b1, n > 10)
    wr(ccs_pkg::FAST_OSC_CONTROL_OFS, 32'h80);
    #1;
    `CHK("fast_osc_en", 1'b1, fast_osc_en)
    wr(ccs_pkg::FAST_OSC_CONTROL_OFS, 32'h0);
    wr(ccs_pkg::OSC_SETTLE_SELECT_OFS, 32'h0);
    pulse(1);
    pulse(2);
    first_tick(n, m);
    `CHK("settle_wait", 1'b1, n >= 2040 && n <= 2070)
    `CHK("status", 1'b1, stat)
    @(posedge pclk);
    strap <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      @(posedge pclk);
      src[i] <= 1'b1;
      repeat (3) @(posedge pclk);
      #1;
      `CHK("held_outputs", 3'h0, {stat, fast_osc_en, slow_osc_en})
      @(posedge pclk);
      src[i] <= 1'b0;
      first_tick(n, m);
      `CHK("start_ticks", 17, m)
    end
    repeat (2100) @(posedge pclk);
    wr(ccs_pkg::MAIN_CLOCK_MODE_OFS, 32'h1);
    wstat(1'b1, n);
    wr(ccs_pkg::SLOW_OSC_MODE_OFS, 32'h1);
    #1;
    `CHK("slow_osc_en", 1'b0, slow_osc_en)
    `CHK("run_state", 2'h3, run_state)
    pulse(0);
    count(5, n);
    pulse(2);
    wr(ccs_pkg::SLOW_OSC_MODE_OFS, 32'h0);
    repeat (10) @(posedge pclk);
    wr(ccs_pkg::MAIN_CLOCK_MODE_OFS, 32'h0);
    wstat(1'b0, n);
    `CHK("switch_down", 1'b1, n >= 1 && n <= 9)
    repeat (80) @(posedge pclk);
    wr(ccs_pkg::FAST_OSC_CONTROL_OFS, 32'h80);
    pulse(0);
    count(10, n);
    `CHK("periph_clk_sel", 1'b0, periph_clk_sel)
    pulse(2);
    give_verdict();
  end
endmodule : ccs_clock_ctrl_test
